//--- isa_id_consts.vh
// Constants for the ISA feature and identification register bank
`ifndef ISA_ID_CONSTS_VH
`define ISA_ID_CONSTS_VH

// --------------------------------------------------------------
// Widths
// --------------------------------------------------------------
`define MNW 64
`define EXT_W 26
`define VENDOR_W 32
`define CSR_ADDR_W 12

// --------------------------------------------------------------
// Register addresses
// --------------------------------------------------------------
`define ADDR_ISA 12'h001
`define ADDR_VENDOR 12'h002
`define ADDR_ARCH 12'h003
`define ADDR_IMPL 12'h004

// --------------------------------------------------------------
// Native width field of the ISA register
// --------------------------------------------------------------
`define MXL_HI 63
`define MXL_LO 62
`define MXL_64 2'h2

// --------------------------------------------------------------
// Extension letter positions
// --------------------------------------------------------------
`define EXT_A 0
`define EXT_B 1
`define EXT_C 2
`define EXT_D 3
`define EXT_E 4
`define EXT_F 5
`define EXT_H 7
`define EXT_I 8
`define EXT_M 12
`define EXT_Q 16
`define EXT_S 18
`define EXT_U 20
`define EXT_V 21
`define EXT_X 23

// Letters G J K L N O P R T W Y Z
`define EXT_RSVD_MASK 26'h34AEE40

// --------------------------------------------------------------
// Vendor identification layout
// --------------------------------------------------------------
`define VID_OFS_W 7
`define VID_BANK_W 25

`endif

//--- isa_legalizer.v
// Turns a software write of the extension field into a legal value
`include "isa_id_consts.vh"

module isa_legalizer (
  input wire [`EXT_W-1:0] i_old,
  input wire [`EXT_W-1:0] i_wdata,
  input wire [`EXT_W-1:0] i_supported,
  input wire [`EXT_W-1:0] i_writable,
  input wire i_has_x,
  output reg [`EXT_W-1:0] o_legal
);

  reg [`EXT_W-1:0] v;

  always @* begin
    v = (i_wdata & i_writable) | (i_old & ~i_writable);
    v = v & i_supported & ~`EXT_RSVD_MASK;
    // Base selection: with no embedded base the full base stays on
    if (!v[`EXT_I] && !i_supported[`EXT_E]) begin
      v[`EXT_I] = 1'b1;
    end
    v[`EXT_E] = ~v[`EXT_I];
    // Dependants fall with what they need
    if (!v[`EXT_F]) begin
      v[`EXT_D] = 1'b0;
    end
    if (!v[`EXT_D]) begin
      v[`EXT_Q] = 1'b0;
    end
    if (!v[`EXT_U]) begin
      v[`EXT_S] = 1'b0;
    end
    if (!v[`EXT_S]) begin
      v[`EXT_H] = 1'b0;
    end
    if (!v[`EXT_D]) begin
      v[`EXT_V] = 1'b0;
    end
    v[`EXT_X] = i_has_x;
    o_legal = v;
  end

endmodule

//--- id_const_bank.v
// Fixed identification values of the hart
`include "isa_id_consts.vh"

module id_const_bank #(
  parameter [`VID_BANK_W-1:0] VENDOR_BANK_NUM = 25'h0000001,
  parameter [`VID_OFS_W-1:0] VENDOR_OFFSET = 7'h00,
  parameter [`MNW-1:0] ARCH_ID = 64'h0000000000000000,
  parameter [`MNW-1:0] IMPL_ID = 64'h0000000000000000
) (
  output wire [`VENDOR_W-1:0] o_vendor,
  output wire [`MNW-1:0] o_arch,
  output wire [`MNW-1:0] o_impl
);

  // Bank field holds the bank number less one; an all-zero id stays zero
  wire [`VID_BANK_W-1:0] bank_field;
  assign bank_field = (VENDOR_BANK_NUM == {`VID_BANK_W{1'b0}}) ?
    {`VID_BANK_W{1'b0}} : VENDOR_BANK_NUM - 25'h0000001;
  assign o_vendor = {bank_field, VENDOR_OFFSET};
  assign o_arch = ARCH_ID;
  assign o_impl = IMPL_ID;

endmodule

//--- isa_id_csr_bank.v
// ISA feature register and identification registers of one hart
//
// Function
// - One presence bit per letter, A to Z
// - Reserved extension bits always read zero
// - Reset loads maximal set, full base preferred
// - Tentative and reserved letters never reported present
// - Non-standard bit set when custom extensions exist
// - Bit-manipulation bit guarantees its three sub-extensions
// - Multiply bit guarantees full multiply and divide
// - Supervisor bit one means supervisor supported
// - User bit one means user mode supported
// - Embedded base bit is inverse of full base
// - Clearing full base bit selects embedded base
// - Dependent feature cleared along with its prerequisite
// - Unsupported combinations replaced by a supported one
// - Misaligning alignment increase suppresses the write
// - Re-enabled extension state may be anything
// - Set bit means implemented; clear proves nothing
// - Read-only 32-bit vendor identification register
// - Bank field is bank number minus one
// - Read-only architecture identification, zero if absent
// - Open ids top bit clear, commercial set
// - Read-only implementation version, zero if absent
// - Implementation value left-justified on nibbles
`include "isa_id_consts.vh"

module isa_id_csr_bank #(
  parameter [`EXT_W-1:0] SUPPORTED = 26'h095112F,
  parameter [`EXT_W-1:0] WRITABLE = 26'h015112C,
  parameter HAS_X = 1'b1,
  parameter ISA_ZERO = 1'b0,
  parameter [`VID_BANK_W-1:0] VENDOR_BANK_NUM = 25'h0000001,
  parameter [`VID_OFS_W-1:0] VENDOR_OFFSET = 7'h00,
  parameter [`MNW-1:0] ARCH_ID = 64'h0000000000000001,
  parameter [`MNW-1:0] IMPL_ID = 64'h1000000000000000
) (
  input wire I_CLK,
  input wire I_RST_N,
  input wire I_CSR_VALID,
  input wire I_CSR_WRITE,
  input wire [`CSR_ADDR_W-1:0] I_CSR_ADDR,
  input wire [`MNW-1:0] I_CSR_WDATA,
  input wire [`MNW-1:0] I_NEXT_PC,
  output reg O_CSR_DONE,
  output reg O_CSR_ILLEGAL,
  output reg [`MNW-1:0] O_CSR_RDATA,
  output reg [`EXT_W-1:0] O_ISA_EXT,
  output reg [`EXT_W-1:0] O_EXT_REENABLED,
  output reg O_WRITE_SUPPRESSED,
  output reg O_EMBEDDED_BASE,
  output reg O_HALF_ALIGN,
  output reg O_SUPERVISOR_OK,
  output reg O_USER_OK,
  output reg O_MULDIV_FULL,
  output reg O_BITMANIP_OK
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Value that the extension field holds out of reset
  function [`EXT_W-1:0] reset_ext;
    input [`EXT_W-1:0] sup;
    input has_x;
    reg [`EXT_W-1:0] v;
    begin
      v = sup & ~`EXT_RSVD_MASK;
      if (sup[`EXT_I]) begin
        v[`EXT_E] = 1'b0;
      end
      v[`EXT_X] = has_x;
      reset_ext = v;
    end
  endfunction

  // Full ISA register image from an extension field
  function [`MNW-1:0] isa_image;
    input [`EXT_W-1:0] ext;
    input zero;
    begin
      if (zero) begin
        isa_image = {`MNW{1'b0}};
      end else begin
        isa_image = {`MXL_64, {(`MNW-`EXT_W-2){1'b0}}, ext};
      end
    end
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam [`EXT_W-1:0] EXT_RESET = reset_ext(SUPPORTED, HAS_X);

  reg [`EXT_W-1:0] ext_r;
  reg [`EXT_W-1:0] ext_nxt;
  reg done_nxt;
  reg illegal_nxt;
  reg [`MNW-1:0] rdata_nxt;
  reg suppress_nxt;
  reg [`EXT_W-1:0] reen_nxt;
  wire [`EXT_W-1:0] legal_ext;
  wire [`VENDOR_W-1:0] vendor_id;
  wire [`MNW-1:0] arch_id;
  wire [`MNW-1:0] impl_id;
  wire hit_isa;
  wire hit_vendor;
  wire hit_arch;
  wire hit_impl;
  wire hit_any;
  wire hit_ro;
  wire isa_wr;
  wire align_up;
  wire pc_misaligned;

  // ------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------
  isa_legalizer u_legal (
    .i_old(ext_r),
    .i_wdata(I_CSR_WDATA[`EXT_W-1:0]),
    .i_supported(SUPPORTED),
    .i_writable(WRITABLE & ~`EXT_RSVD_MASK),
    .i_has_x(HAS_X[0]),
    .o_legal(legal_ext)
  );

  id_const_bank #(
    .VENDOR_BANK_NUM(VENDOR_BANK_NUM),
    .VENDOR_OFFSET(VENDOR_OFFSET),
    .ARCH_ID(ARCH_ID),
    .IMPL_ID(IMPL_ID)
  ) u_ids (
    .o_vendor(vendor_id),
    .o_arch(arch_id),
    .o_impl(impl_id)
  );

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  assign hit_isa = (I_CSR_ADDR == `ADDR_ISA);
  assign hit_vendor = (I_CSR_ADDR == `ADDR_VENDOR);
  assign hit_arch = (I_CSR_ADDR == `ADDR_ARCH);
  assign hit_impl = (I_CSR_ADDR == `ADDR_IMPL);
  assign hit_ro = hit_vendor | hit_arch | hit_impl;
  assign hit_any = hit_isa | hit_ro;
  assign isa_wr = I_CSR_VALID & I_CSR_WRITE & hit_isa & ~ISA_ZERO;

  // ------------------------------------------------------------
  // Alignment guard
  // ------------------------------------------------------------
  // Dropping compressed raises alignment from 16 to 32 bits
  assign align_up = ext_r[`EXT_C] & ~legal_ext[`EXT_C];
  assign pc_misaligned = I_NEXT_PC[1];

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always @* begin
    ext_nxt = ext_r;
    suppress_nxt = 1'b0;
    reen_nxt = {`EXT_W{1'b0}};
    done_nxt = I_CSR_VALID;
    illegal_nxt = 1'b0;
    rdata_nxt = {`MNW{1'b0}};
    if (I_CSR_VALID) begin
      // Reads return the value held before this access
      if (hit_isa) begin
        rdata_nxt = isa_image(ext_r, ISA_ZERO[0]);
      end else if (hit_vendor) begin
        rdata_nxt = {{(`MNW-`VENDOR_W){1'b0}}, vendor_id};
      end else if (hit_arch) begin
        rdata_nxt = arch_id;
      end else if (hit_impl) begin
        rdata_nxt = impl_id;
      end
      if (!hit_any) begin
        illegal_nxt = 1'b1;
      end else if (I_CSR_WRITE && hit_ro) begin
        // Identification values never change
        illegal_nxt = 1'b1;
      end
    end
    if (isa_wr) begin
      if (align_up && pc_misaligned) begin
        suppress_nxt = 1'b1;
      end else begin
        ext_nxt = legal_ext;
        // Flag newly enabled letters; their private state is not restored
        reen_nxt = legal_ext & ~ext_r;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ext_r <= EXT_RESET;
    end else begin
      ext_r <= ext_nxt;
    end
  end

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CSR_DONE <= 1'b0;
      O_CSR_ILLEGAL <= 1'b0;
      O_CSR_RDATA <= {`MNW{1'b0}};
      O_WRITE_SUPPRESSED <= 1'b0;
      O_EXT_REENABLED <= {`EXT_W{1'b0}};
    end else begin
      O_CSR_DONE <= done_nxt;
      O_CSR_ILLEGAL <= illegal_nxt;
      O_CSR_RDATA <= rdata_nxt;
      O_WRITE_SUPPRESSED <= suppress_nxt;
      O_EXT_REENABLED <= reen_nxt;
    end
  end

  // ------------------------------------------------------------
  // Capability outputs to the rest of the hart
  // ------------------------------------------------------------
  // Registered from the next value so they track the field exactly
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_ISA_EXT <= EXT_RESET;
      O_EMBEDDED_BASE <= EXT_RESET[`EXT_E];
      O_HALF_ALIGN <= EXT_RESET[`EXT_C];
      O_SUPERVISOR_OK <= EXT_RESET[`EXT_S];
      O_USER_OK <= EXT_RESET[`EXT_U];
      O_MULDIV_FULL <= EXT_RESET[`EXT_M];
      O_BITMANIP_OK <= EXT_RESET[`EXT_B];
    end else begin
      O_ISA_EXT <= ext_nxt;
      O_EMBEDDED_BASE <= ext_nxt[`EXT_E];
      O_HALF_ALIGN <= ext_nxt[`EXT_C];
      O_SUPERVISOR_OK <= ext_nxt[`EXT_S];
      O_USER_OK <= ext_nxt[`EXT_U];
      // Multiply-only support elsewhere is not gated by this bit
      O_MULDIV_FULL <= ext_nxt[`EXT_M];
      O_BITMANIP_OK <= ext_nxt[`EXT_B];
    end
  end

endmodule

//--- isa_id_csr_bank_properties.sv
// Concurrent checks of the ISA feature and identification register bank
`include "isa_id_consts.vh"
module isa_id_csr_bank_checker (
  input wire I_CLK,
  input wire I_RST_N,
  input wire I_CSR_VALID,
  input wire I_CSR_WRITE,
  input wire [11:0] I_CSR_ADDR,
  input wire [63:0] I_CSR_WDATA,
  input wire [63:0] I_NEXT_PC,
  input wire O_CSR_DONE,
  input wire O_CSR_ILLEGAL,
  input wire [63:0] O_CSR_RDATA,
  input wire [25:0] O_ISA_EXT,
  input wire [25:0] O_EXT_REENABLED,
  input wire O_WRITE_SUPPRESSED,
  input wire O_EMBEDDED_BASE,
  input wire O_HALF_ALIGN,
  input wire O_SUPERVISOR_OK,
  input wire O_USER_OK,
  input wire O_MULDIV_FULL,
  input wire O_BITMANIP_OK
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  wire wr_isa = I_CSR_VALID && I_CSR_WRITE && I_CSR_ADDR == `ADDR_ISA;
  wire wr_id = I_CSR_VALID && I_CSR_WRITE && I_CSR_ADDR >= `ADDR_VENDOR
    && I_CSR_ADDR <= `ADDR_IMPL;
  sequence s_req;
    I_CSR_VALID;
  endsequence
  sequence s_ans;
    O_CSR_DONE;
  endsequence
  property p_done;
    s_req |=> s_ans;
  endproperty
  a_done: assert property (p_done) else $error("access not answered");
  property p_id_ro;
    wr_id |=> O_CSR_ILLEGAL && $stable(O_ISA_EXT);
  endproperty
  a_id_ro: assert property (p_id_ro) else $error("id write accepted");
  property p_sup;
    wr_isa && O_ISA_EXT[`EXT_C] && !I_CSR_WDATA[`EXT_C] && I_NEXT_PC[1]
      |=> O_WRITE_SUPPRESSED && !O_CSR_ILLEGAL && $stable(O_ISA_EXT);
  endproperty
  a_sup: assert property (p_sup) else $error("misaligned write kept");
  property p_reen;
    O_CSR_DONE |-> O_EXT_REENABLED == (O_ISA_EXT & ~$past(O_ISA_EXT));
  endproperty
  a_reen: assert property (p_reen) else $error("reenable mask wrong");
  property p_rsvd;
    (O_ISA_EXT & `EXT_RSVD_MASK) == 26'h0000000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_e_inv;
    O_ISA_EXT[`EXT_E] != O_ISA_EXT[`EXT_I];
  endproperty
  a_e_inv: assert property (p_e_inv) else $error("base bits not inverse");
  property p_x;
    O_ISA_EXT[`EXT_X];
  endproperty
  a_x: assert property (p_x) else $error("custom bit clear");
  property p_lvl;
    O_EMBEDDED_BASE == O_ISA_EXT[`EXT_E] && O_SUPERVISOR_OK == O_ISA_EXT[`EXT_S]
      && O_USER_OK == O_ISA_EXT[`EXT_U] && O_MULDIV_FULL == O_ISA_EXT[`EXT_M]
      && O_BITMANIP_OK == O_ISA_EXT[`EXT_B] && O_HALF_ALIGN == O_ISA_EXT[`EXT_C];
  endproperty
  a_lvl: assert property (p_lvl) else $error("capability level wrong");
  property p_dep;
    !(O_ISA_EXT[`EXT_D] && !O_ISA_EXT[`EXT_F]) && !(O_ISA_EXT[`EXT_S] && !O_ISA_EXT[`EXT_U]);
  endproperty
  a_dep: assert property (p_dep) else $error("dependency broken");
endmodule

bind isa_id_csr_bank isa_id_csr_bank_checker isa_id_csr_bank_checker_inst (.*);

//--- testbench.sv
// Self-checking testbench of the ISA feature and identification register bank
`include "isa_id_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // Identification values are arbitrary
  localparam [24:0] VB = 25'h0000003;
  localparam [6:0] VO = 7'h15;
  localparam [63:0] AID = 64'h0000000000000007;
  localparam [63:0] IID = 64'h1200000000000000;
  localparam [25:0] RX = 26'h095112F;
  reg I_CLK = 1'b0;
  reg I_RST_N = 1'b0;
  reg I_CSR_VALID = 1'b0;
  reg I_CSR_WRITE = 1'b0;
  reg [11:0] I_CSR_ADDR = 12'h000;
  reg [63:0] I_CSR_WDATA = 64'h0;
  reg [63:0] I_NEXT_PC = 64'h0;
  wire O_CSR_DONE, O_CSR_ILLEGAL, O_WRITE_SUPPRESSED, O_EMBEDDED_BASE, O_HALF_ALIGN;
  wire O_SUPERVISOR_OK, O_USER_OK, O_MULDIV_FULL, O_BITMANIP_OK;
  wire [63:0] O_CSR_RDATA;
  wire [25:0] O_ISA_EXT, O_EXT_REENABLED;
  integer errors = 0;
  integer n_compared = 0;
  integer k;
  reg [63:0] rd;
  reg [63:0] idv [0:2];
  reg ill, sup;
  reg [25:0] ren;
  isa_id_csr_bank #(.VENDOR_BANK_NUM(VB), .VENDOR_OFFSET(VO), .ARCH_ID(AID), .IMPL_ID(IID))
    isa_id_csr_bank_inst (.*);
  initial forever #25 I_CLK = ~I_CLK;
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task test_done;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input [63:0] g, input [63:0] e);
    n_compared = n_compared + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Holds the request for one edge only, since the block answers on the next
  task acc(input w, input [11:0] a, input [63:0] d, input [63:0] pc);
    integer i;
    I_CSR_VALID <= 1'b1;
    I_CSR_WRITE <= w;
    I_CSR_ADDR <= a;
    I_CSR_WDATA <= d;
    I_NEXT_PC <= pc;
    @(posedge I_CLK);
    I_CSR_VALID <= 1'b0;
    #1;
    for (i = 0; i < 4 && O_CSR_DONE !== 1'b1; i = i + 1)
      @(posedge I_CLK) #1;
    if (i == 4) begin
      errors = errors + 1;
      test_done;
    end
    rd = O_CSR_RDATA;
    ill = O_CSR_ILLEGAL;
    sup = O_WRITE_SUPPRESSED;
    ren = O_EXT_REENABLED;
    @(posedge I_CLK);
  endtask
  task wr(input [25:0] d, input pc1);
    acc(1'b1, `ADDR_ISA, {38'h0, d}, {62'h0, pc1, 1'b0});
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    idv[0] = {32'h0, VB - 25'h0000001, VO};
    idv[1] = AID;
    idv[2] = IID;
    repeat (6) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    @(posedge I_CLK);
    chk(O_ISA_EXT, RX);
    chk({O_EMBEDDED_BASE, O_HALF_ALIGN, O_SUPERVISOR_OK}, 3'h3);
    chk({O_USER_OK, O_MULDIV_FULL, O_BITMANIP_OK}, 3'h7);
    acc(1'b0, `ADDR_ISA, 64'h0, 64'h0);
    chk(rd, {`MXL_64, 36'h0, RX});
    for (k = 0; k < 3; k = k + 1) begin
      acc(1'b0, `ADDR_VENDOR + k, 64'h0, 64'h0);
      chk(rd, idv[k]);
      acc(1'b1, `ADDR_VENDOR + k, 64'hFFFFFFFFFFFFFFFF, 64'h0);
      chk(ill, 1'b1);
      acc(1'b0, `ADDR_VENDOR + k, 64'h0, 64'h0);
      chk(rd, idv[k]);
    end
    acc(1'b0, 12'h005, 64'h0, 64'h0);
    chk({ill, rd[62:0]}, {1'b1, 63'h0});
    wr(26'h3FFFFFF, 1'b0);
    chk(O_ISA_EXT, RX);
    // Dropping single precision takes double and then quad with it
    wr(RX & ~26'h0000020, 1'b0);
    chk(O_ISA_EXT, 26'h0941107);
    wr(26'h0951107 & ~26'h0100000, 1'b0);
    chk(O_ISA_EXT, 26'h0801107);
    chk({O_SUPERVISOR_OK, O_USER_OK}, 2'h0);
    wr(RX, 1'b0);
    chk(ren, 26'h0150028);
    wr(RX & ~26'h0000100, 1'b0);
    chk({O_EMBEDDED_BASE, O_ISA_EXT}, {1'b0, RX});
    wr(RX & ~26'h0001000, 1'b0);
    chk({O_MULDIV_FULL, O_ISA_EXT}, {1'b0, RX & ~26'h0001000});
    wr(RX & ~26'h0000004, 1'b1);
    chk({sup, ill, O_ISA_EXT}, {2'h2, RX & ~26'h0001000});
    wr(RX & ~26'h0000004, 1'b0);
    chk({sup, O_HALF_ALIGN, O_ISA_EXT}, {2'h0, RX & ~26'h0000004});
    wr(RX, 1'b1);
    chk({sup, O_ISA_EXT}, {1'b0, RX});
    // Clearing every writable bit leaves only what legalisation forces
    wr(26'h0000000, 1'b0);
    chk(O_ISA_EXT, 26'h0800103);
    // Reset in mid-run restores the full set but leaves the vendor id alone
    I_RST_N <= 1'b0;
    repeat (2) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    @(posedge I_CLK);
    chk(O_ISA_EXT, RX);
    acc(1'b0, `ADDR_VENDOR, 64'h0, 64'h0);
    chk(rd, idv[0]);
    test_done;
  end
endmodule
